/* File: core/ato_pkg.sv */
// ato_pkg: constants for the autonomous transmit timeout supervisor.
// assumes a 40 MHz ref_clk and a 32-bit axi4-lite register bus.
package ato_pkg;
   // register byte offsets
   localparam logic [7:0] RESTART_OFS = 8'h6C;
   localparam logic [7:0] CONFIG_OFS = 8'h26;
   localparam logic [7:0] INPUT_OFS = 8'h22;
   localparam logic [7:0] STATUS_OFS = 8'h00;
   // field positions
   localparam int PWR_BIT = 4;
   localparam int TXREAD_BIT = 7;
   localparam int SERV_BIT = 6;
   localparam int IRQ_BIT = 0;
   localparam int FIRED_BIT = 1;
   localparam int FILT_BIT = 2;
   // reset values
   localparam logic [7:0] CONFIG_RST = 8'h00;
   // timing
   localparam int CLK_HZ = 40_000_000;
   localparam int FILT_HZ = 492;
   localparam int FILT_DIV = CLK_HZ / FILT_HZ;
   localparam int SEC_DIV = CLK_HZ;
   localparam int TIMEOUT_S = 30;
   localparam int HOLDOFF_S = 1;
   localparam int FILT_W = 10;
   localparam logic [1:0] AXI_OKAY = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage

/* File: core/ato_top.sv */
// ato_top: timeout supervisor with carrier filter and axi4-lite registers.
// assumes pin inputs asynchronous to ref_clk; one write and one read at a time.
// Overview of operation
// R1: counter reaching thirty seconds unrestarted starts the timeout reset sequence.
// R2: any accepted restart register write restarts the counter, data ignored.
// R3: master reset input clears the timeout counter.
// R4: restart refused only when filtered carrier low and transmit power high.
// R5: processor gets no indication whether restart was accepted.
// R6: watchdog reset does not clear the timeout counter.
// R7: carrier filtered by 10-bit up/down counter ticked at 492Hz.
// R8: filter counter saturates at maximum and at zero.
// R9: filtered carrier is the filter counter's top bit.
// R10: on timeout an interrupt is raised first.
// R11: at least one second later power-off output driven low.
// R12: after firing nothing software does cancels the pending power-off.
// R13: master reset forces power-off output low.
// R14: configuration bit 4 sets the power-off output level directly.
// R15: timeout reset only ever drives power-off low.
// R16: watchdog reset leaves power-off output unchanged.
// R17: service mode disables timeout reset; boot code drives power-off high.
// R18: power-off low held about one second; state undefined afterward.
// R19: raw transmit power level readable at input port bit 7.
// R20: software should restart well inside the thirty-second period.
// R21: filter and second ticks come from parameterised prescalers of ref_clk.
`timescale 1ns/1ps
`default_nettype none
module ato_top #(
   parameter int FILT_DIV = ato_pkg::FILT_DIV,
   parameter int SEC_DIV = ato_pkg::SEC_DIV,
   parameter int TIMEOUT_S = ato_pkg::TIMEOUT_S,
   parameter int HOLDOFF_S = ato_pkg::HOLDOFF_S
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic master_reset_in_n,
   input wire logic watchdog_reset,
   input wire logic rx_carrier_detect,
   input wire logic tx_power_detect,
   input wire logic service_mode,
   output logic power_off_n,
   output logic timeout_irq,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int FILT_W_L = ato_pkg::FILT_W;
   typedef enum logic [1:0] {IDLE, HOLD, DONE} ato_state_e;
   typedef struct packed {
      logic [2:0] mr_sy;
      logic [1:0] rx_sy;
      logic [1:0] tx_sy;
      logic [1:0] sv_sy;
      logic [31:0] fdiv;
      logic [31:0] sdiv;
      logic [FILT_W_L-1:0] filt;
      logic [7:0] secs;
      ato_state_e st;
      logic irq;
      logic pwr;
      logic [7:0] cfg;
      logic aw_got;
      logic w_got;
      logic [7:0] awa;
      logic [7:0] wd;
      logic wsb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ato_state_s;
   ato_state_s q_r, q_nxt;
   logic mr_n, rx_s, tx_s, sv_s, ftick, stick, carrier, accept, wr_go, rd_go;
   assign mr_n = q_r.mr_sy[1];
   assign rx_s = q_r.rx_sy[1];
   assign tx_s = q_r.tx_sy[1];
   assign sv_s = q_r.sv_sy[1];
   assign ftick = (q_r.fdiv == 32'(FILT_DIV - 1)); // [R21]
   assign stick = (q_r.sdiv == 32'(SEC_DIV - 1)); // [R21]
   assign carrier = q_r.filt[FILT_W_L-1]; // [R9]
   assign accept = carrier || !tx_s; // [R4]
   assign wr_go = q_r.aw_got && q_r.w_got && !q_r.bvalid;
   assign rd_go = s_axi_arvalid && !q_r.rvalid;
   always_comb begin
      q_nxt = q_r;
      q_nxt.mr_sy = {1'b0, q_r.mr_sy[0], master_reset_in_n};
      q_nxt.rx_sy = {q_r.rx_sy[0], rx_carrier_detect};
      q_nxt.tx_sy = {q_r.tx_sy[0], tx_power_detect};
      q_nxt.sv_sy = {q_r.sv_sy[0], service_mode};
      q_nxt.fdiv = ftick ? 32'h0000_0000 : q_r.fdiv + 32'h0000_0001;
      q_nxt.sdiv = stick ? 32'h0000_0000 : q_r.sdiv + 32'h0000_0001;
      // saturating up/down filter
      if (ftick) begin
         if (rx_s && q_r.filt != '1) begin
            q_nxt.filt = q_r.filt + 1'b1; // [R7] [R8]
         end else if (!rx_s && q_r.filt != '0) begin
            q_nxt.filt = q_r.filt - 1'b1; // [R7] [R8]
         end
      end
      // axi write side; restart and config writes answer okay, hiding acceptance; other addresses get slverr
      if (s_axi_awvalid && !q_r.aw_got) begin
         q_nxt.aw_got = 1'b1;
         q_nxt.awa = s_axi_awaddr;
      end
      // data kept with the beat: the master drops it once taken
      if (s_axi_wvalid && !q_r.w_got) begin
         q_nxt.w_got = 1'b1;
         q_nxt.wd = s_axi_wdata[7:0];
         q_nxt.wsb = s_axi_wstrb[0];
      end
      if (wr_go) begin
         q_nxt.aw_got = 1'b0;
         q_nxt.w_got = 1'b0;
         q_nxt.bvalid = 1'b1;
         q_nxt.bresp = ato_pkg::AXI_OKAY; // [R5]
         if (q_r.awa == ato_pkg::CONFIG_OFS) begin
            if (q_r.wsb) begin
               q_nxt.cfg = q_r.wd;
            end
         end else if (q_r.awa != ato_pkg::RESTART_OFS) begin
            q_nxt.bresp = ato_pkg::AXI_SLVERR;
         end
      end
      if (q_r.bvalid && s_axi_bready) begin
         q_nxt.bvalid = 1'b0;
      end
      // timeout counter counts whole seconds
      if (q_r.st == IDLE && !sv_s) begin
         if (wr_go && q_r.awa == ato_pkg::RESTART_OFS && accept) begin
            q_nxt.secs = 8'h00; // [R2]
         end else if (stick) begin
            if (q_r.secs == 8'(TIMEOUT_S - 1)) begin
               q_nxt.secs = 8'h00;
               q_nxt.st = HOLD; // [R1]
               q_nxt.irq = 1'b1; // [R10]
            end else begin
               q_nxt.secs = q_r.secs + 8'h01;
            end
         end
      end
      // restart writes no longer reach the counter once fired
      if (q_r.st == HOLD && stick) begin // [R12]
         q_nxt.secs = q_r.secs + 8'h01;
         if (q_r.secs == 8'(HOLDOFF_S)) begin
            q_nxt.st = DONE; // [R11]
            q_nxt.pwr = 1'b0; // [R15]
         end
      end
      // software level follows config bit; in done the low level stands
      // next state, so the low level lands with the entry into done
      if (q_nxt.st != DONE) begin
         q_nxt.pwr = q_nxt.cfg[ato_pkg::PWR_BIT]; // [R14] [R17]
      end
      // axi read side
      if (rd_go) begin
         q_nxt.rvalid = 1'b1;
         q_nxt.rresp = ato_pkg::AXI_OKAY;
         case (s_axi_araddr)
            ato_pkg::CONFIG_OFS: q_nxt.rdata = {24'h00_0000, q_r.cfg};
            ato_pkg::INPUT_OFS: begin
               q_nxt.rdata = 32'h0000_0000;
               q_nxt.rdata[ato_pkg::TXREAD_BIT] = tx_s; // [R19]
               q_nxt.rdata[ato_pkg::SERV_BIT] = sv_s;
            end
            ato_pkg::STATUS_OFS: begin
               q_nxt.rdata = 32'h0000_0000;
               q_nxt.rdata[ato_pkg::IRQ_BIT] = q_r.irq;
               q_nxt.rdata[ato_pkg::FIRED_BIT] = (q_r.st != IDLE);
               q_nxt.rdata[ato_pkg::FILT_BIT] = carrier;
            end
            default: begin
               q_nxt.rdata = 32'h0000_0000;
               q_nxt.rresp = ato_pkg::AXI_SLVERR;
            end
         endcase
      end
      if (q_r.rvalid && s_axi_rready) begin
         q_nxt.rvalid = 1'b0;
      end
      // master reset pin: clears counter and forces output low
      if (!mr_n) begin
         q_nxt.secs = 8'h00; // [R3]
         q_nxt.st = IDLE;
         q_nxt.irq = 1'b0;
         q_nxt.cfg = ato_pkg::CONFIG_RST;
         q_nxt.pwr = 1'b0; // [R13]
         q_nxt.filt = '0;
      end
      // watchdog_reset deliberately touches neither secs nor pwr [R6] [R16]
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         q_r <= '0;
         q_r.mr_sy <= 3'b000;
      end else begin
         q_r <= q_nxt;
      end
   end
   assign power_off_n = q_r.pwr;
   assign timeout_irq = q_r.irq;
   assign s_axi_awready = !q_r.aw_got;
   assign s_axi_wready = !q_r.w_got;
   assign s_axi_bvalid = q_r.bvalid;
   assign s_axi_bresp = q_r.bresp;
   assign s_axi_arready = !q_r.rvalid;
   assign s_axi_rvalid = q_r.rvalid;
   assign s_axi_rdata = q_r.rdata;
   assign s_axi_rresp = q_r.rresp;
   // R18 behaviour: low level holds until a master reset clears done and software sets config bit 4 again.

   sequence fire_s;
      q_r.st == IDLE ##1 q_r.st == HOLD;
   endsequence
   fire_irq_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
      fire_s |-> q_r.irq) else $error("irq not raised on timeout");
   pwr_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R11]
      $rose(q_r.st == DONE) |-> $past(q_r.st) == HOLD && !q_r.pwr)
      else $error("power-off not driven low on expiry");
   only_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R15]
      q_r.st == DONE && mr_n |=> !q_r.pwr) else $error("timeout path drove output high");
   no_cancel_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R12]
      q_r.st == HOLD && mr_n |=> q_r.st != IDLE) else $error("pending power-off cancelled");
   mr_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
      !mr_n |=> q_r.secs == 8'h00 && !q_r.pwr) else $error("master reset did not clear");
   refuse_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R4]
      wr_go && q_r.awa == ato_pkg::RESTART_OFS && !carrier && tx_s && mr_n
      && q_r.st == IDLE && !stick && !sv_s |=> q_r.secs == $past(q_r.secs))
      else $error("refused restart changed counter");
   restart_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
      wr_go && q_r.awa == ato_pkg::RESTART_OFS && accept && q_r.st == IDLE && !sv_s
      |=> q_r.secs == 8'h00) else $error("accepted restart ignored");
   filt_sat_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8]
      ftick && rx_s && q_r.filt == '1 && mr_n |=> q_r.filt == '1)
      else $error("filter wrapped at maximum");
   sw_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R14]
      q_r.st != DONE && mr_n ##1 q_r.st != DONE |-> q_r.pwr == q_r.cfg[ato_pkg::PWR_BIT])
      else $error("output not following config bit");
   serv_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R17]
      sv_s && q_r.st == IDLE && mr_n |=> q_r.st == IDLE) else $error("timeout fired in service");

   // filter steps, the restart strobe and the hold state as reusable pieces
   sequence filt_up_s;
      ftick && rx_s && q_r.filt != '1 && mr_n;
   endsequence

   sequence filt_dn_s;
      ftick && !rx_s && q_r.filt != '0 && mr_n;
   endsequence

   sequence restart_hit_s;
      wr_go && q_r.awa == ato_pkg::RESTART_OFS;
   endsequence

   sequence hold_s;
      q_r.st == HOLD && mr_n;
   endsequence

   filt_up_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7]
      filt_up_s |=> q_r.filt == $past(q_r.filt) + 10'h001)
      else $error("filter did not count up");

   filt_dn_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7]
      filt_dn_s |=> q_r.filt == $past(q_r.filt) - 10'h001)
      else $error("filter did not count down");

   filt_floor_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8]
      ftick && !rx_s && q_r.filt == '0 && mr_n |=> q_r.filt == '0)
      else $error("filter wrapped below zero");

   filt_still_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7]
      !ftick && mr_n |=> $stable(q_r.filt))
      else $error("filter moved between ticks");

   irq_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
      q_r.irq && mr_n |=> q_r.irq)
      else $error("timeout interrupt dropped");

   irq_cause_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
      $rose(q_r.irq) |-> q_r.st == HOLD)
      else $error("interrupt without timeout");

   fire_secs_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
      $rose(q_r.st == HOLD) |-> $past(q_r.secs) == 8'(TIMEOUT_S - 1))
      else $error("timeout fired at wrong count");

   hold_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R11]
      hold_s ##0 !stick |=> q_r.st == HOLD)
      else $error("power-off taken before its second");

   restart_ok_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R5]
      restart_hit_s |=> q_r.bresp == ato_pkg::AXI_OKAY)
      else $error("restart answer revealed acceptance");

   fired_deaf_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R12]
      restart_hit_s ##0 (q_r.st != IDLE && mr_n) |=> q_r.st != IDLE)
      else $error("restart cancelled pending power-off");

   wd_count_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
      watchdog_reset && mr_n && !stick && !wr_go |=> q_r.secs == $past(q_r.secs))
      else $error("watchdog reset touched counter");

   wd_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R16]
      watchdog_reset && mr_n && q_r.st == IDLE && !wr_go
      |=> q_r.pwr == $past(q_r.cfg[ato_pkg::PWR_BIT]))
      else $error("watchdog reset touched power output");

   cfg_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R14]
      wr_go && q_r.awa == ato_pkg::CONFIG_OFS && q_r.wsb && mr_n |=> q_r.cfg == $past(q_r.wd))
      else $error("config write lost");

   tick_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R21]
      stick |=> q_r.sdiv == 32'h0000_0000)
      else $error("second prescaler did not wrap");

   serv_freeze_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R17]
      sv_s && q_r.st == IDLE && mr_n |=> q_r.secs == $past(q_r.secs))
      else $error("counter ran in service mode");

   tx_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R19]
      rd_go && s_axi_araddr == ato_pkg::INPUT_OFS |=> q_r.rdata[ato_pkg::TXREAD_BIT] == $past(tx_s))
      else $error("transmit level not read back");

   mr_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R13]
      !mr_n |=> !q_r.irq && q_r.st == IDLE)
      else $error("master reset left timeout state");

   bresp_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      q_r.bvalid && !s_axi_bready |=> q_r.bvalid && $stable(q_r.bresp))
      else $error("write response withdrawn");

   rdata_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      q_r.rvalid && !s_axi_rready |=> q_r.rvalid && $stable(q_r.rdata))
      else $error("read data withdrawn");
endmodule
`default_nettype wire

/* File: test/ato_partner.sv */
// ato_partner: radio detectors and master reset source facing the supervisor.
// assumes the bench requests levels; outputs change just after ref_clk edges.
`timescale 1ns/1ps
`default_nettype none
module ato_partner (
   input wire logic ref_clk,
   input wire logic carrier_on,
   input wire logic tx_on,
   input wire logic mreset_on,
   output logic rx_carrier_detect = 1'h0,
   output logic tx_power_detect = 1'h0,
   output logic master_reset_in_n = 1'h1
);
   // comparator outputs: full levels, never left floating
   always @(posedge ref_clk) begin
      rx_carrier_detect <= carrier_on;
      tx_power_detect <= tx_on;
      master_reset_in_n <= !mreset_on;
   end
endmodule
`default_nettype wire

/* File: test/ato_top_tb.sv */
// ato_top_tb: register level tests of the timeout supervisor.
// assumes shortened prescalers: one second is 20 cycles, one filter tick 4.
`timescale 1ns/1ps
`default_nettype none
module ato_top_tb;
   logic ref_clk = 1'h0, rst_n = 1'h0, carrier_on = 1'h0, tx_on = 1'h0, mreset_on = 1'h0;
   logic watchdog_reset = 1'h0, service_mode = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rd;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [1:0] rs;
   wire rx_cd, tx_pd, mr_n, power_off_n, timeout_irq, awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int errors = 0, tests_run = 0, cyc = 0, n;
   ato_partner prt_u (.ref_clk(ref_clk), .carrier_on(carrier_on), .tx_on(tx_on),
      .mreset_on(mreset_on), .rx_carrier_detect(rx_cd), .tx_power_detect(tx_pd),
      .master_reset_in_n(mr_n));
   ato_top #(.FILT_DIV(4), .SEC_DIV(20), .TIMEOUT_S(30), .HOLDOFF_S(1)) dut_u (
      .ref_clk(ref_clk), .rst_n(rst_n), .master_reset_in_n(mr_n),
      .watchdog_reset(watchdog_reset), .rx_carrier_detect(rx_cd), .tx_power_detect(tx_pd),
      .service_mode(service_mode), .power_off_n(power_off_n), .timeout_irq(timeout_irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   task automatic print_verdict();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // values read right after the edge are still the pre-edge ones
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      forever begin
         @(posedge ref_clk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid && bready) break;
      end
      rs = bresp;
      bready <= 1'h0;
   endtask
   task automatic axr(input logic [7:0] a);
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      forever begin
         @(posedge ref_clk);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid && rready) break;
      end
      rd = rdata;
      rs = rresp;
      rready <= 1'h0;
   endtask
   // restart far inside the period so one late write never trips it
   task automatic keepalive(input int k);
      repeat (k) begin
         repeat (400) @(posedge ref_clk);
         axw(ato_pkg::RESTART_OFS, 32'h0000_00A5);
      end
   endtask
   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         print_verdict();
      end
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'h1;
      chk(32'(power_off_n), 32'h0);
      axr(8'h40);
      chk(32'(rs), 32'(ato_pkg::AXI_SLVERR));
      tx_on <= 1'h1;
      axw(ato_pkg::CONFIG_OFS, 32'h0000_0010);
      axr(ato_pkg::CONFIG_OFS);
      chk(rd & 32'h0000_00FF, 32'h0000_0010);
      chk(32'(power_off_n), 32'h1);
      axr(ato_pkg::INPUT_OFS);
      chk(32'(rd[ato_pkg::TXREAD_BIT]), 32'h1);
      service_mode <= 1'h1;
      repeat (800) @(posedge ref_clk);
      chk(32'(timeout_irq), 32'h0);
      service_mode <= 1'h0;
      mreset_on <= 1'h1;
      repeat (6) @(posedge ref_clk);
      chk(32'(power_off_n), 32'h0);
      mreset_on <= 1'h0;
      tx_on <= 1'h0;
      repeat (6) @(posedge ref_clk);
      axw(ato_pkg::CONFIG_OFS, 32'h0000_0010);
      keepalive(3);
      chk(32'(timeout_irq), 32'h0);
      chk(32'(rs), 32'(ato_pkg::AXI_OKAY));
      watchdog_reset <= 1'h1;
      repeat (4) @(posedge ref_clk);
      watchdog_reset <= 1'h0;
      chk(32'(power_off_n), 32'h1);
      carrier_on <= 1'h1;
      keepalive(6);
      axr(ato_pkg::STATUS_OFS);
      chk(32'(rd[ato_pkg::FILT_BIT]), 32'h1);
      tx_on <= 1'h1;
      keepalive(3);
      chk(32'(timeout_irq), 32'h0);
      carrier_on <= 1'h0;
      tx_on <= 1'h0;
      keepalive(6);
      axr(ato_pkg::STATUS_OFS);
      chk(32'(rd[ato_pkg::FILT_BIT]), 32'h0);
      tx_on <= 1'h1;
      repeat (300) @(posedge ref_clk);
      axw(ato_pkg::RESTART_OFS, 32'h0000_0000);
      n = 0;
      while (timeout_irq !== 1'h1 && n < 900) begin
         @(posedge ref_clk);
         n++;
      end
      chk(32'(n > 200 && n < 400), 32'h1);
      chk(32'(power_off_n), 32'h1);
      tx_on <= 1'h0;
      axw(ato_pkg::RESTART_OFS, 32'h0000_00FF);
      repeat (8) @(posedge ref_clk);
      chk(32'(power_off_n), 32'h1);
      n = 0;
      while (power_off_n !== 1'h0 && n < 80) begin
         @(posedge ref_clk);
         n++;
      end
      chk(32'(n < 80), 32'h1);
      axw(ato_pkg::CONFIG_OFS, 32'h0000_0010);
      repeat (4) @(posedge ref_clk);
      chk(32'(power_off_n), 32'h0);
      axr(ato_pkg::STATUS_OFS);
      chk(32'(rd[ato_pkg::IRQ_BIT]), 32'h1);
      print_verdict();
   end
endmodule
`default_nettype wire
